// ---- rtl/rct_timer.sv ----
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
// Notes on behaviour
// [R1] - mode from clock selects, capture select, run
// [R2] - counter select high counts count pin
// [R3] - counter select low counts system clock
// [R4] - reload mode: overflow flags and reloads
// [R5] - capture mode: trigger edge copies count
// [R6] - clock select high gives baud generator
// [R7] - no overflow flag in baud mode
// [R8] - receiver clock from this or other
// [R9] - transmitter clock from this or other
// [R10] - trigger edges only with trigger enable
// [R11] - count by one, single-cycle overflow pulse
module rct_timer (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // pins
    input wire logic event_count_pin,
    input wire logic trigger_pin,
    // serial port clocking
    input wire logic other_timer_ovf,
    output logic rx_baud_tick,
    output logic tx_baud_tick,
    // interrupt
    output logic irq
);
    logic [5:0] ctrl_r, ctrl_nxt; // control bits
    logic [1:0] status_r, status_nxt; // sticky events
    logic [1:0] mask_r, mask_nxt; // interrupt mask
    logic [15:0] count_r, count_nxt; // count_high:count_low
    logic [15:0] reload_r, reload_nxt; // reload_high:reload_low
    logic dp_wr_r, dp_wr_nxt; // write data phase pending
    logic [4:0] dp_addr_r, dp_addr_nxt; // its offset
    logic [31:0] rdata_r, rdata_nxt; // read data
    logic rx_tick_r, rx_tick_nxt;
    logic tx_tick_r, tx_tick_nxt;
    logic ev_fall; // falling edge on count pin
    logic trig_fall; // falling edge on trigger pin
    logic ap_take; // address phase accepted
    logic wr_ctrl, wr_mask, wr_count, wr_reload;
    logic tick; // one count step this cycle
    logic ovf; // overflow pulse
    logic trig_evt; // enabled trigger edge
    logic baud; // baud-rate generator mode
    logic rd_status; // status read accepted, clears the sticky bits
    logic irq_r, irq_nxt; // registered interrupt level
    rct_pkg::rct_mode_e mode; // decoded operating mode

    // offset match, shared by the write strobes and the clear-on-read
    function automatic logic is_off(input logic [4:0] a, input logic [4:0] off);
        return a == off;
    endfunction

    // run low stops the timer whatever the other bits say
    function automatic rct_pkg::rct_mode_e mode_of(input logic [5:0] c);
        if (!c[rct_pkg::CTRL_RUN]) begin // [R1]
            return rct_pkg::RCT_STOP;
        end else if (c[rct_pkg::CTRL_RXS] || c[rct_pkg::CTRL_TXS]) begin // [R6]
            return rct_pkg::RCT_BAUD;
        end else if (c[rct_pkg::CTRL_CRS]) begin // [R5]
            return rct_pkg::RCT_CAPTURE;
        end
        return rct_pkg::RCT_RELOAD; // [R4]
    endfunction

    // pins come from outside the clock domain: two flops before any logic
    rct_pin_sync i_rct_pin_sync_ev (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin(event_count_pin),
        .level(),
        .fall(ev_fall)
    );
    rct_pin_sync i_rct_pin_sync_trig (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin(trigger_pin),
        .level(),
        .fall(trig_fall)
    );

    // bus side: zero wait states, always an okay response
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_r;
    assign ap_take = hsel && htrans[1] && hready;
    // the status read clears in its address phase; the word is latched at the same edge
    assign rd_status = ap_take && !hwrite && is_off(haddr[4:0], rct_pkg::OFF_STATUS);
    // writes land at the end of the data phase, when hwdata stands
    assign wr_ctrl = dp_wr_r && hready && is_off(dp_addr_r, rct_pkg::OFF_CTRL);
    assign wr_mask = dp_wr_r && hready && is_off(dp_addr_r, rct_pkg::OFF_MASK);
    assign wr_count = dp_wr_r && hready && is_off(dp_addr_r, rct_pkg::OFF_COUNT);
    assign wr_reload = dp_wr_r && hready && is_off(dp_addr_r, rct_pkg::OFF_RELOAD);

    // bus next values: pending write, its offset and the read word
    always_comb begin
        dp_wr_nxt = dp_wr_r;
        dp_addr_nxt = dp_addr_r;
        rdata_nxt = rdata_r;
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        if (hready) begin
            dp_wr_nxt = ap_take && hwrite;
            if (ap_take) begin
                dp_addr_nxt = haddr[4:0];
            end
        end
        // read word taken before any clear, so a set flag is seen once
        if (ap_take && !hwrite) begin
            case (haddr[4:0])
                rct_pkg::OFF_CTRL: rdata_nxt = {26'h0000000, ctrl_r};
                rct_pkg::OFF_STATUS: rdata_nxt = {30'h00000000, status_r};
                rct_pkg::OFF_MASK: rdata_nxt = {30'h00000000, mask_r};
                rct_pkg::OFF_COUNT: rdata_nxt = {16'h0000, count_r};
                rct_pkg::OFF_RELOAD: rdata_nxt = {16'h0000, reload_r};
                default: rdata_nxt = 32'h00000000; // unmapped offsets read zero
            endcase
        end
        if (wr_ctrl) begin
            ctrl_nxt = hwdata[rct_pkg::CTRL_W-1:0];
        end
        if (wr_mask) begin
            mask_nxt = hwdata[rct_pkg::ST_W-1:0];
        end
    end

    // bus registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r <= 1'b0;
            dp_addr_r <= 5'h00;
            rdata_r <= 32'h00000000;
            ctrl_r <= rct_pkg::CTRL_RST;
            mask_r <= rct_pkg::ST_RST;
        end else begin
            dp_wr_r <= dp_wr_nxt;
            dp_addr_r <= dp_addr_nxt;
            rdata_r <= rdata_nxt;
            ctrl_r <= ctrl_nxt;
            mask_r <= mask_nxt;
        end
    end

    // mode and count step
    assign mode = mode_of(ctrl_r); // [R1]
    assign baud = (mode == rct_pkg::RCT_BAUD); // [R6]
    // counter select picks the pin edge, else every system clock counts
    assign tick = (mode != rct_pkg::RCT_STOP) && (ctrl_r[rct_pkg::CTRL_CTS] ? ev_fall : 1'b1); // [R2] [R3]
    assign ovf = tick && (count_r == rct_pkg::COUNT_MAX); // [R11]
    // trigger edges are dropped unless enabled
    assign trig_evt = ctrl_r[rct_pkg::CTRL_TEN] && trig_fall && (mode != rct_pkg::RCT_STOP); // [R10]

    // timer next values: count, reload word and sticky status
    always_comb begin
        count_nxt = count_r;
        reload_nxt = reload_r;
        status_nxt = status_r;
        // clear first so that an event in the same cycle wins
        if (rd_status) begin
            status_nxt = rct_pkg::ST_RST;
        end
        if (ovf && mode != rct_pkg::RCT_CAPTURE) begin
            count_nxt = reload_r; // [R4] [R6]
        end else if (tick) begin
            count_nxt = count_r + 16'h0001; // [R11]
        end
        // an enabled trigger edge forces a reload in reload mode
        if (trig_evt && mode == rct_pkg::RCT_RELOAD) begin
            count_nxt = reload_r; // [R10]
        end
        // and copies the count in capture mode
        if (trig_evt && mode == rct_pkg::RCT_CAPTURE) begin
            reload_nxt = count_r; // [R5]
        end
        // baud mode keeps the flag alone; software alone clears it
        if (ovf && !baud) begin
            status_nxt[rct_pkg::ST_OVF] = 1'b1; // [R4] [R7]
        end
        if (trig_evt && !baud) begin
            status_nxt[rct_pkg::ST_TRIG] = 1'b1; // [R5]
        end
        // a software write beats the running count
        if (wr_count) begin
            count_nxt = hwdata[15:0];
        end
        if (wr_reload) begin
            reload_nxt = hwdata[15:0];
        end
    end

    // timer registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r <= rct_pkg::COUNT_RST;
            reload_r <= rct_pkg::COUNT_RST;
            status_r <= rct_pkg::ST_RST;
        end else begin
            count_r <= count_nxt;
            reload_r <= reload_nxt;
            status_r <= status_nxt;
        end
    end

    // serial clock routing and interrupt level; one cycle late, which the port never notices
    always_comb begin
        rx_tick_nxt = ctrl_r[rct_pkg::CTRL_RXS] ? (ovf && baud) : other_timer_ovf; // [R8]
        tx_tick_nxt = ctrl_r[rct_pkg::CTRL_TXS] ? (ovf && baud) : other_timer_ovf; // [R9]
        irq_nxt = |(status_r & mask_r);
    end

    // output registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_tick_r <= 1'b0;
            tx_tick_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            rx_tick_r <= rx_tick_nxt;
            tx_tick_r <= tx_tick_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign rx_baud_tick = rx_tick_r;
    assign tx_baud_tick = tx_tick_r;
    assign irq = irq_r;

    // stopped timer keeps its count unless software writes it
    a_stop_holds: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
        (!ctrl_r[rct_pkg::CTRL_RUN] && !wr_count) |=> $stable(count_r))
        else $error("count moved while stopped");

    // ordinary step adds exactly one
    a_count_step: assert property (@(posedge hclk) disable iff (!hresetn) // [R11]
        (tick && !ovf && !wr_count && !(trig_evt && mode == rct_pkg::RCT_RELOAD))
        |=> count_r == $past(count_r) + 16'h0001)
        else $error("count step is not one");

    // overflow outside capture mode loads the reload word
    a_reload_load: assert property (@(posedge hclk) disable iff (!hresetn) // [R4]
        (ovf && mode != rct_pkg::RCT_CAPTURE && !wr_count) |=> count_r == $past(reload_r))
        else $error("overflow did not reload");

    // overflow outside baud mode leaves the flag set
    a_flag_set: assert property (@(posedge hclk) disable iff (!hresetn) // [R4]
        (ovf && !baud) |=> status_r[rct_pkg::ST_OVF])
        else $error("overflow flag not set");

    // baud mode never raises the flag
    a_baud_no_flag: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
        (ovf && baud && !status_r[rct_pkg::ST_OVF]) |=> !status_r[rct_pkg::ST_OVF])
        else $error("flag set in baud mode");

    // enabled trigger edge copies the count in capture mode
    a_capture_copy: assert property (@(posedge hclk) disable iff (!hresetn) // [R5]
        (trig_evt && mode == rct_pkg::RCT_CAPTURE && !wr_reload) |=> reload_r == $past(count_r))
        else $error("capture did not copy");

    // without trigger enable the captured word stays put
    a_trig_ignored: assert property (@(posedge hclk) disable iff (!hresetn) // [R10]
        (!ctrl_r[rct_pkg::CTRL_TEN] && !wr_reload) |=> $stable(reload_r))
        else $error("trigger acted while disabled");

    // transmitter clocked by this overflow when selected
    a_tx_route: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
        (ctrl_r[rct_pkg::CTRL_TXS] && ovf) |=> tx_baud_tick)
        else $error("transmit tick missing");

    // receiver follows the other timer when not selected
    a_rx_route: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
        (!ctrl_r[rct_pkg::CTRL_RXS]) |=> rx_baud_tick == $past(other_timer_ovf))
        else $error("receive tick not routed");
endmodule

// ---- rtl/rct_pkg.sv ----
package rct_pkg;
    // register byte offsets
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_STATUS = 5'h04;
    localparam logic [4:0] OFF_MASK = 5'h08;
    localparam logic [4:0] OFF_COUNT = 5'h0C;
    localparam logic [4:0] OFF_RELOAD = 5'h10;
    // control register field positions
    localparam int CTRL_CRS = 0;
    localparam int CTRL_CTS = 1;
    localparam int CTRL_RUN = 2;
    localparam int CTRL_TEN = 3;
    localparam int CTRL_TXS = 4;
    localparam int CTRL_RXS = 5;
    localparam int CTRL_W = 6;
    // status and mask field positions
    localparam int ST_OVF = 0;
    localparam int ST_TRIG = 1;
    localparam int ST_W = 2;
    // reset values
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [1:0] ST_RST = 2'h0;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    // operating modes
    typedef enum logic [1:0] {RCT_STOP, RCT_RELOAD, RCT_CAPTURE, RCT_BAUD} rct_mode_e;
endpackage

// ---- rtl/rct_pin_sync.sv ----
`timescale 1ns/1ns
// two-stage synchroniser with a falling-edge pulse taken after the second stage
module rct_pin_sync (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // pin side
    input wire logic pin,
    // synchronous side
    output logic level,
    output logic fall
);
    logic meta_r; // first stage, read only by the second
    logic sync_r; // second stage
    logic prev_r; // delayed copy for edge detection
    logic meta_nxt;
    logic sync_nxt;
    logic prev_nxt;

    // next values: plain shift
    always_comb begin
        meta_nxt = pin;
        sync_nxt = meta_r;
        prev_nxt = sync_r;
    end

    // idle pins are high, so reset to high avoids a false edge at release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
        end
    end

    assign level = sync_r;
    assign fall = prev_r & ~sync_r;
endmodule

// ---- testbench/rct_partner.sv ----
`timescale 1ns/1ns
// far side: count pin and trigger pin idle high, other timer's overflow idle low
module rct_partner (
    // clock
    input wire logic hclk,
    // pins
    output logic ecp,
    output logic trp,
    output logic oto
);
    initial begin
        ecp = 1'b1;
        trp = 1'b1;
        oto = 1'b0;
    end
    // n falling edges, each level held two cycles so the synchroniser sees it
    task automatic ev_pulses(input int n);
        repeat (n) begin
            @(posedge hclk);
            ecp <= 1'b0;
            repeat (2) @(posedge hclk);
            ecp <= 1'b1;
            repeat (2) @(posedge hclk);
        end
    endtask
    // one falling edge on the trigger pin
    task automatic trig_fall;
        @(posedge hclk);
        trp <= 1'b0;
        repeat (4) @(posedge hclk);
        trp <= 1'b1;
        repeat (2) @(posedge hclk);
    endtask
    // one overflow pulse from the other timer
    task automatic other_pulse;
        @(posedge hclk);
        oto <= 1'b1;
        @(posedge hclk);
        oto <= 1'b0;
    endtask
endmodule

// ---- testbench/tb_reload_capture_baud_timer.sv ----
`timescale 1ns/1ns
module tb_reload_capture_baud_timer;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rdy, rsp, ecp, trp, oto, rxt, txt, irq;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    int bad_count = 0, samples_checked = 0, ticks = 0, rx_ticks = 0;
    always #50 hclk = ~hclk;
    always @(posedge hclk) if (txt === 1) ticks++;
    always @(posedge hclk) if (rxt === 1) rx_ticks++;
    rct_partner i_rct_partner (.hclk(hclk), .ecp(ecp), .trp(trp), .oto(oto));
    rct_timer i_rct_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hreadyout(rdy), .hresp(rsp),
        .hrdata(hrdata), .event_count_pin(ecp), .trigger_pin(trp), .other_timer_ovf(oto),
        .rx_baud_tick(rxt), .tx_baud_tick(txt), .irq(irq));
    // one single transfer, waits on hready in both phases
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        hsel <= 1;
        htrans <= rct_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {27'h0, a};
        do @(posedge hclk); while (rdy !== 1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (rdy !== 1);
        rd = hrdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d fails %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // timer fed from a quiet pin must hold its count
    task automatic t_hold;
        bus(0, rct_pkg::OFF_CTRL, 0);
        chk("ctrl", 0, rd);
        bus(1, rct_pkg::OFF_COUNT, 5);
        bus(1, rct_pkg::OFF_CTRL, 6);
        repeat (10) @(posedge hclk);
        bus(0, rct_pkg::OFF_COUNT, 0);
        chk("count", 5, rd);
        chk("hresp", 0, rsp);
        $display("hold done");
    endtask
    // three pin edges, three counts
    task automatic t_events;
        bus(1, rct_pkg::OFF_COUNT, 0);
        bus(1, rct_pkg::OFF_CTRL, 6);
        i_rct_partner.ev_pulses(3);
        repeat (4) @(posedge hclk);
        bus(1, rct_pkg::OFF_CTRL, 0);
        bus(0, rct_pkg::OFF_COUNT, 0);
        chk("events", 3, rd);
        $display("events done");
    endtask
    // trigger edge ignored while disabled, captured while enabled
    task automatic t_capture;
        logic [31:0] rld;
        bus(1, rct_pkg::OFF_RELOAD, 0);
        bus(1, rct_pkg::OFF_COUNT, 32'h100);
        bus(1, rct_pkg::OFF_CTRL, 5);
        i_rct_partner.trig_fall;
        bus(0, rct_pkg::OFF_RELOAD, 0);
        chk("no capture", 0, rd);
        bus(1, rct_pkg::OFF_CTRL, 13);
        i_rct_partner.trig_fall;
        bus(1, rct_pkg::OFF_CTRL, 0);
        bus(0, rct_pkg::OFF_RELOAD, 0);
        rld = rd;
        bus(0, rct_pkg::OFF_COUNT, 0);
        chk("capture", 1, rld > 32'h100 && rld < rd);
        bus(0, rct_pkg::OFF_STATUS, 0);
        chk("trigger flag", 2, rd);
        $display("capture done");
    endtask
    // unmasked overflow raises the interrupt, a status read drops it
    task automatic t_irq;
        bus(1, rct_pkg::OFF_MASK, 1);
        bus(1, rct_pkg::OFF_COUNT, 32'hFFF0);
        bus(1, rct_pkg::OFF_CTRL, 4);
        repeat (20) @(posedge hclk);
        bus(1, rct_pkg::OFF_CTRL, 0);
        chk("irq set", 1, irq);
        bus(0, rct_pkg::OFF_STATUS, 0);
        repeat (2) @(posedge hclk);
        chk("irq clear", 0, irq);
        bus(1, rct_pkg::OFF_MASK, 0);
        $display("irq done");
    endtask
    // with both selects low the serial clocks follow the other timer
    task automatic t_route;
        ticks = 0;
        rx_ticks = 0;
        i_rct_partner.other_pulse;
        repeat (3) @(posedge hclk);
        chk("rx from other", 1, rx_ticks);
        chk("tx from other", 1, ticks);
        $display("route done");
    endtask
    // reload mode then baud mode from the same reload value
    task automatic t_run(input logic [31:0] c, input logic [31:0] f, input string n);
        bus(1, rct_pkg::OFF_RELOAD, 32'hFFF0);
        bus(1, rct_pkg::OFF_COUNT, 32'hFFF0);
        bus(1, rct_pkg::OFF_CTRL, c);
        repeat (40) @(posedge hclk);
        bus(1, rct_pkg::OFF_CTRL, 0);
        bus(0, rct_pkg::OFF_COUNT, 0);
        chk(n, 32'hFFF, rd[15:4]);
        bus(0, rct_pkg::OFF_STATUS, 0);
        chk(n, f, rd[0]);
        bus(0, rct_pkg::OFF_STATUS, 0);
        chk(n, 0, {irq, rd[0]});
        $display("%s done", n);
    endtask
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1;
        t_hold;
        t_events;
        t_capture;
        t_run(4, 1, "reload");
        t_run(32'h34, 0, "baud");
        chk("tx", 1, ticks != 0);
        chk("rx", 1, rx_ticks != 0);
        t_route;
        t_irq;
        finish_test;
    end
    // watchdog far beyond the few hundred cycles needed
    initial begin
        #500000;
        bad_count++;
        finish_test;
    end
endmodule
